/* File: verif/interrupt_priority_vector_config_tb.sv */
`timescale 1ns/1ps
`include "ipvc_defines.svh"

module interrupt_priority_vector_config_tb;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [`IPVC_SEL_W-1:0] reg_sel = '0;
  logic [31:0] reg_wdata = 32'h00000000;
  logic [31:0] reg_rdata;
  logic reg_rvalid;
  logic [6:0] src = 7'h00;
  logic nmi_pin_b = 1'b1;
  logic nmi_mux_sel = 1'b0;
  logic nmi_req, irq_req, core_ack, core_exit, en = 1'b0;
  logic [3:0] irq_num;
  logic [5:0] irq_vector, stacked_vector;
  logic [1:0] irq_prio;
  logic [31:0] irq_vec_addr;
  ipvc_pkg::ipvc_exc_kind_e exc_kind;
  int n_mismatch = 0;
  int comparisons = 0;
  logic [3:0] nums [7] = '{4'h5, 4'h6, 4'h7, 4'h8, 4'ha, 4'hb, 4'hc};
  logic [1:0] prios [7] = '{2'h3, 2'h3, 2'h3, 2'h0, 2'h1, 2'h0, 2'h3};

  always #4 sys_clk = ~sys_clk;

  ipvc_top ipvc_top_inst (.sys_clk(sys_clk), .rst_b(rst_b), .ce(1'b1),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_sel(reg_sel), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .flash_cmd_irq(src[0]), .power_supervisor_irq(src[1]), .ext_pin_irq(src[2]),
    .two_wire_unit_zero_irq(src[3]), .serial_periph_unit_zero_irq(src[4]),
    .serial_periph_unit_one_irq(src[5]), .async_serial_unit_zero_irq(src[6]),
    .nmi_pin_b(nmi_pin_b), .nmi_mux_sel(nmi_mux_sel), .nmi_req(nmi_req),
    .irq_req(irq_req), .irq_num(irq_num), .irq_vector(irq_vector), .irq_prio(irq_prio),
    .irq_vec_addr(irq_vec_addr), .core_ack(core_ack), .core_exit(core_exit),
    .stacked_vector(stacked_vector), .exc_kind(exc_kind));

  ipvc_core_model ipvc_core_model_inst (.sys_clk(sys_clk), .rst_b(rst_b), .en(en),
    .irq_req(irq_req), .core_ack(core_ack), .core_exit(core_exit));

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("unexpected t=%0t got %h exp %h", $time, got, exp);
      n_mismatch++;
    end
  endtask : chk

  task automatic hang();
    n_mismatch++;
    $display("unexpected t=%0t got %h exp %h", $time, 1'b0, 1'b1);
    summarize();
  endtask : hang

  task automatic wr(input logic [2:0] s, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_sel <= s;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] s, input logic [31:0] e);
    int i;
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_sel <= s;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    for (i = 0; i < 4 && reg_rvalid !== 1'b1; i++) begin
      @(posedge sys_clk);
      #1;
    end
    if (i == 4) hang();
    chk(reg_rdata, e);
  endtask : rd

  // Sources are levels; the offer follows one edge after they land
  task automatic offer(input logic [6:0] v, input logic [3:0] n, input logic [1:0] p);
    int i;
    @(posedge sys_clk);
    src <= v;
    repeat (2) @(posedge sys_clk);
    #1;
    for (i = 0; i < 8 && irq_req !== 1'b1; i++) begin
      @(posedge sys_clk);
      #1;
    end
    if (i == 8) hang();
    chk(irq_num, n);
    chk(irq_prio, p);
    chk(irq_vector, n + 6'h10);
    chk(irq_vec_addr, {n + 6'h10, 2'b00});
  endtask : offer

  initial begin
    int i;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    for (i = 0; i < 4; i++) rd(3'(i), 32'h00000000);
    $display("test reset values done");
    for (i = 0; i < 8; i++) wr(3'(i), 32'hffffffff);
    for (i = 0; i < 4; i++) rd(3'(i), `IPVC_FIELD_MASK);
    for (i = 4; i < 8; i++) rd(3'(i), 32'h00000000);
    wr(0, 32'h00000000);
    wr(2, 32'h3f7f3f3f);
    rd(2, 32'h00400000);
    // Write straight into a read of the same register; sources 0-3 are unassigned
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_sel <= 3'h0;
    reg_wdata <= 32'h5a5a5a5a;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rvalid, 1'b1);
    chk(reg_rdata, 32'h40404040);
    $display("test field layout done");
    for (i = 0; i < 7; i++) offer(7'h01 << i, nums[i], prios[i]);
    offer(7'h41, 4'h5, 2'h3);
    offer(7'h49, 4'h8, 2'h0);
    $display("test offers done");
    offer(7'h01, 4'h5, 2'h3);
    @(posedge sys_clk);
    en <= 1'b1;
    for (i = 0; i < 8 && core_ack !== 1'b1; i++) begin
      @(posedge sys_clk);
      #1;
    end
    if (i == 8) hang();
    @(posedge sys_clk);
    #1;
    chk(stacked_vector, 6'h15);
    chk(exc_kind, ipvc_pkg::IPVC_EXC_PERIPH);
    chk(irq_req, 1'b0);
    @(posedge sys_clk);
    en <= 1'b0;
    src <= 7'h00;
    repeat (8) @(posedge sys_clk);
    $display("test service done");
    nmi_mux_sel <= 1'b1;
    nmi_pin_b <= 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
    chk(nmi_req, 1'b1);
    @(posedge sys_clk);
    nmi_mux_sel <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk(nmi_req, 1'b0);
    @(posedge sys_clk);
    nmi_pin_b <= 1'b1;
    repeat (4) @(posedge sys_clk);
    nmi_pin_b <= 1'b0;
    repeat (5) @(posedge sys_clk);
    #1;
    chk(nmi_req, 1'b0);
    $display("test nmi done");
    summarize();
  end
endmodule : interrupt_priority_vector_config_tb

/* File: verif/ipvc_core_model.sv */
`timescale 1ns/1ps

// ==========================================================
// Core stand-in: takes an offered request, then returns later
module ipvc_core_model #(
  parameter int EXIT_DLY = 4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Control from bench
  input wire logic en,
  // Core side of the controller
  input wire logic irq_req,
  output logic core_ack,
  output logic core_exit
);
  logic busy_reg;
  logic [7:0] cnt_reg;

  // One-cycle ack only while idle, so a handler is never taken twice
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      core_ack <= 1'b0;
      core_exit <= 1'b0;
      busy_reg <= 1'b0;
      cnt_reg <= 8'h00;
    end else begin
      core_ack <= 1'b0;
      core_exit <= 1'b0;
      if (busy_reg) begin
        cnt_reg <= cnt_reg + 8'h01;
        if (cnt_reg == EXIT_DLY[7:0]) begin
          core_exit <= 1'b1;
          busy_reg <= 1'b0;
        end
      end else if (en && irq_req && !core_ack) begin
        core_ack <= 1'b1;
        busy_reg <= 1'b1;
        cnt_reg <= 8'h00;
      end
    end
  end
endmodule : ipvc_core_model

/* File: verilog/ipvc_defines.svh */
`ifndef IPVC_DEFINES_SVH
`define IPVC_DEFINES_SVH

// ==========================================================
// Priority field layout
`define IPVC_NUM_LEVELS 4
`define IPVC_PRIO_W 2
`define IPVC_FIELDS_PER_REG 4
`define IPVC_FIELD_STRIDE 8
`define IPVC_FIELD_BASE 6
`define IPVC_FIELD_MASK 32'hc0c0c0c0
`define IPVC_PRIO_RESET 2'h0
`define IPVC_NUM_PRIO_REGS 4
`define IPVC_SEL_W 3

// ==========================================================
// Peripheral sources
`define IPVC_NUM_IRQ 13
`define IPVC_ASSIGNED_MASK 13'h1de0
`define IPVC_SRC_FLASH 4'h5
`define IPVC_SRC_POWER 4'h6
`define IPVC_SRC_EXT_PIN 4'h7
`define IPVC_SRC_TWI0 4'h8
`define IPVC_SRC_SPU0 4'ha
`define IPVC_SRC_SPU1 4'hb
`define IPVC_SRC_ASU0 4'hc

// ==========================================================
// Vector table
`define IPVC_IRQ_VEC_BASE 6'h10
`define IPVC_TABLE_BASE 32'h00000000
`define IPVC_VEC_SHIFT 2
`define IPVC_PERIPH_VEC_ADDR 32'h00000040
`define IPVC_VEC_STACK 6'h00
`define IPVC_VEC_RESET_PC 6'h01
`define IPVC_VEC_NMI 6'h02
`define IPVC_VEC_HARD 6'h03
`define IPVC_VEC_SVC 6'h0b
`define IPVC_VEC_PEND 6'h0e
`define IPVC_VEC_TICK 6'h0f

`endif

/* File: verilog/ipvc_pkg.sv */
package ipvc_pkg;

  typedef enum logic [0:0] {
    IPVC_ST_IDLE = 1'b0,
    IPVC_ST_SERVICE = 1'b1
  } ipvc_state_e;

  typedef enum logic [3:0] {
    IPVC_EXC_STACK = 4'h0,
    IPVC_EXC_RESET_PC = 4'h1,
    IPVC_EXC_NMI = 4'h2,
    IPVC_EXC_HARD = 4'h3,
    IPVC_EXC_SVC = 4'h4,
    IPVC_EXC_PEND = 4'h5,
    IPVC_EXC_TICK = 4'h6,
    IPVC_EXC_RESERVED = 4'h7,
    IPVC_EXC_PERIPH = 4'h8
  } ipvc_exc_kind_e;

endpackage : ipvc_pkg

/* File: verilog/ipvc_prio_mem.sv */
`timescale 1ns/1ps
`include "ipvc_defines.svh"

module ipvc_prio_mem #(
  parameter int NUM_REGS = `IPVC_NUM_PRIO_REGS,
  parameter int SEL_W = `IPVC_SEL_W
) (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic ce,
  // Access port
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [SEL_W-1:0] sel,
  input wire logic [31:0] wdata,
  output logic [31:0] rd_data,
  output logic rd_valid,
  // Every field, source n at bits 2n+1:2n
  output logic [NUM_REGS*8-1:0] prio_flat
);

  localparam int NF = NUM_REGS * `IPVC_FIELDS_PER_REG;

  logic [1:0] field_reg [NF];
  logic [1:0] field_next [NF];
  logic [31:0] rd_data_reg, rd_data_next;
  logic rd_valid_reg, rd_valid_next;

  function automatic int field_lsb(input int slot);
    field_lsb = `IPVC_FIELD_STRIDE * slot + `IPVC_FIELD_BASE;
  endfunction : field_lsb

  function automatic logic sel_ok(input logic [SEL_W-1:0] s);
    sel_ok = (int'(s) < NUM_REGS);
  endfunction : sel_ok

  // ==========================================================
  // Field storage; only the two top bits of each byte exist
  always_comb begin
    for (int f = 0; f < NF; f++) begin
      field_next[f] = field_reg[f];
      if (wr_en && sel_ok(sel) && (int'(sel) == f / 4)) begin
        field_next[f] = wdata[field_lsb(f % 4) +: 2];
      end
    end
    rd_valid_next = rd_en;
    rd_data_next = 32'h00000000;
    if (rd_en && sel_ok(sel)) begin
      for (int s = 0; s < 4; s++) begin
        rd_data_next[field_lsb(s) +: 2] = field_reg[int'(sel) * 4 + s];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int f = 0; f < NF; f++) begin
        field_reg[f] <= `IPVC_PRIO_RESET;
      end
      rd_data_reg <= 32'h00000000;
      rd_valid_reg <= 1'b0;
    end else if (ce) begin
      field_reg <= field_next;
      rd_data_reg <= rd_data_next;
      rd_valid_reg <= rd_valid_next;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NF; g++) begin : g_flat
      assign prio_flat[2*g +: 2] = field_reg[g];
    end
  endgenerate

  assign rd_data = rd_data_reg;
  assign rd_valid = rd_valid_reg;

endmodule : ipvc_prio_mem

/* File: verilog/ipvc_top.sv */
// Contract
// - Four priority levels, two-bit field each.
// - Fields at 31:30,23:22,15:14,7:6; rest zero.
// - NMI request comes from active-low pin.
// - Pin raises NMI only when muxed to NMI.
// - Source number equals vector number minus 16.
// - Serviced vector number is the stacked value.
// - Vectors four bytes apart; sources 0-4,9 unassigned.
// - Core vectors fixed; others below 16 reserved.
// - Sources 5,6,7: flash, low-voltage, external pin.
// - Sources 8,10,11,12: two-wire, serial, async units.
// - Register number is source divided by four.
// - Field starts at 8*(source mod 4)+6.
`timescale 1ns/1ps
`include "ipvc_defines.svh"

module ipvc_top #(
  parameter int NUM_IRQ = `IPVC_NUM_IRQ,
  parameter int NUM_REGS = `IPVC_NUM_PRIO_REGS
) (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic ce,
  // Priority register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [`IPVC_SEL_W-1:0] reg_sel,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  // Peripheral sources, same clock
  input wire logic flash_cmd_irq,
  input wire logic power_supervisor_irq,
  input wire logic ext_pin_irq,
  input wire logic two_wire_unit_zero_irq,
  input wire logic serial_periph_unit_zero_irq,
  input wire logic serial_periph_unit_one_irq,
  input wire logic async_serial_unit_zero_irq,
  // Non-maskable pin
  input wire logic nmi_pin_b,
  input wire logic nmi_mux_sel,
  output logic nmi_req,
  // Core side
  output logic irq_req,
  output logic [3:0] irq_num,
  output logic [5:0] irq_vector,
  output logic [1:0] irq_prio,
  output logic [31:0] irq_vec_addr,
  input wire logic core_ack,
  input wire logic core_exit,
  output logic [5:0] stacked_vector,
  output ipvc_pkg::ipvc_exc_kind_e exc_kind
);

  logic [NUM_REGS*8-1:0] prio_flat;
  logic [NUM_IRQ-1:0] pend;
  logic best_found;
  logic [3:0] best_num;
  logic [1:0] best_prio;

  function automatic logic [31:0] vec_addr(input logic [5:0] v);
    vec_addr = `IPVC_TABLE_BASE + (32'(v) << `IPVC_VEC_SHIFT);
  endfunction : vec_addr

  function automatic ipvc_pkg::ipvc_exc_kind_e vec_kind(input logic [5:0] v);
    case (v)
      `IPVC_VEC_STACK: vec_kind = ipvc_pkg::IPVC_EXC_STACK;
      `IPVC_VEC_RESET_PC: vec_kind = ipvc_pkg::IPVC_EXC_RESET_PC;
      `IPVC_VEC_NMI: vec_kind = ipvc_pkg::IPVC_EXC_NMI;
      `IPVC_VEC_HARD: vec_kind = ipvc_pkg::IPVC_EXC_HARD;
      `IPVC_VEC_SVC: vec_kind = ipvc_pkg::IPVC_EXC_SVC;
      `IPVC_VEC_PEND: vec_kind = ipvc_pkg::IPVC_EXC_PEND;
      `IPVC_VEC_TICK: vec_kind = ipvc_pkg::IPVC_EXC_TICK;
      default: begin
        vec_kind = (v >= `IPVC_IRQ_VEC_BASE) ? ipvc_pkg::IPVC_EXC_PERIPH
                                             : ipvc_pkg::IPVC_EXC_RESERVED;
      end
    endcase
  endfunction : vec_kind

  // ==========================================================
  // Priority storage
  ipvc_prio_mem #(
    .NUM_REGS(NUM_REGS),
    .SEL_W(`IPVC_SEL_W)
  ) ipvc_prio_mem_inst (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .ce(ce),
    .wr_en(reg_wr),
    .rd_en(reg_rd),
    .sel(reg_sel),
    .wdata(reg_wdata),
    .rd_data(reg_rdata),
    .rd_valid(reg_rvalid),
    .prio_flat(prio_flat)
  );

  // ==========================================================
  // Non-maskable path; pin is asynchronous, so two flops first
  logic nmi_meta_reg, nmi_sync_reg, nmi_req_reg;
  logic nmi_meta_next, nmi_sync_next, nmi_req_next;

  always_comb begin
    nmi_meta_next = nmi_pin_b;
    nmi_sync_next = nmi_meta_reg;
    nmi_req_next = nmi_mux_sel && !nmi_sync_reg;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      nmi_meta_reg <= 1'b1;
      nmi_sync_reg <= 1'b1;
      nmi_req_reg <= 1'b0;
    end else if (ce) begin
      nmi_meta_reg <= nmi_meta_next;
      nmi_sync_reg <= nmi_sync_next;
      nmi_req_reg <= nmi_req_next;
    end
  end

  assign nmi_req = nmi_req_reg;

  // ==========================================================
  // Source map and selection; lowest level value wins, ties to lower number
  always_comb begin
    pend = '0;
    pend[`IPVC_SRC_FLASH] = flash_cmd_irq;
    pend[`IPVC_SRC_POWER] = power_supervisor_irq;
    pend[`IPVC_SRC_EXT_PIN] = ext_pin_irq;
    pend[`IPVC_SRC_TWI0] = two_wire_unit_zero_irq;
    pend[`IPVC_SRC_SPU0] = serial_periph_unit_zero_irq;
    pend[`IPVC_SRC_SPU1] = serial_periph_unit_one_irq;
    pend[`IPVC_SRC_ASU0] = async_serial_unit_zero_irq;
    pend = pend & `IPVC_ASSIGNED_MASK;
    best_found = 1'b0;
    best_num = 4'h0;
    best_prio = 2'h0;
    for (int i = 0; i < NUM_IRQ; i++) begin
      if (pend[i] && (!best_found || prio_flat[2*i +: 2] < best_prio)) begin
        best_found = 1'b1;
        best_num = 4'(i);
        best_prio = prio_flat[2*i +: 2];
      end
    end
  end

  // ==========================================================
  // Offer and service tracking. Nesting is one deep: a preempting
  // source replaces the active one and exit returns to idle unless a take lands in the same cycle.
  ipvc_pkg::ipvc_state_e state_reg, state_next;
  logic req_reg, req_next;
  logic [3:0] num_reg, num_next;
  logic [1:0] prio_reg, prio_next;
  logic [1:0] act_prio_reg, act_prio_next;
  logic [5:0] stk_reg, stk_next;
  logic take;

  assign take = core_ack && req_reg;

  always_comb begin
    state_next = state_reg;
    act_prio_next = act_prio_reg;
    stk_next = stk_reg;
    case (state_reg)
      ipvc_pkg::IPVC_ST_IDLE: begin
        if (take) begin
          state_next = ipvc_pkg::IPVC_ST_SERVICE;
        end
      end
      ipvc_pkg::IPVC_ST_SERVICE: begin
        if (core_exit && !take) begin
          state_next = ipvc_pkg::IPVC_ST_IDLE;
        end
      end
      default: state_next = ipvc_pkg::IPVC_ST_IDLE;
    endcase
    if (take) begin
      stk_next = `IPVC_IRQ_VEC_BASE + {2'b00, num_reg};
      act_prio_next = prio_reg;
    end
    req_next = best_found && !take;
    if (state_next == ipvc_pkg::IPVC_ST_SERVICE && best_prio >= act_prio_next) begin
      req_next = 1'b0;
    end
    num_next = best_num;
    prio_next = best_prio;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ipvc_pkg::IPVC_ST_IDLE;
      req_reg <= 1'b0;
      num_reg <= 4'h0;
      prio_reg <= 2'h0;
      act_prio_reg <= 2'h0;
      stk_reg <= 6'h00;
    end else if (ce) begin
      state_reg <= state_next;
      req_reg <= req_next;
      num_reg <= num_next;
      prio_reg <= prio_next;
      act_prio_reg <= act_prio_next;
      stk_reg <= stk_next;
    end
  end

  assign irq_req = req_reg;
  assign irq_num = num_reg;
  assign irq_prio = prio_reg;
  assign irq_vector = `IPVC_IRQ_VEC_BASE + {2'b00, num_reg};
  assign irq_vec_addr = vec_addr(irq_vector);
  assign stacked_vector = stk_reg;
  assign exc_kind = vec_kind(stk_reg);

  // ==========================================================
  // Checks
  localparam logic [12:0] ASSIGNED_SRC = `IPVC_ASSIGNED_MASK;

  property p_nmi_from_pin;
    @(posedge sys_clk) disable iff (!rst_b || !ce)
      (!nmi_pin_b && nmi_mux_sel)[*4] |-> nmi_req;
  endproperty
  a_nmi_from_pin: assert property (p_nmi_from_pin) else $error("NMI pin low, no request");

  property p_nmi_mux;
    @(posedge sys_clk) disable iff (!rst_b || !ce)
      !nmi_mux_sel |=> !nmi_req;
  endproperty
  a_nmi_mux: assert property (p_nmi_mux) else $error("NMI raised while pin not muxed");

  property p_vec_num;
    @(posedge sys_clk) disable iff (!rst_b || !ce)
      irq_req |-> (irq_vector - 6'd16 == {2'b00, irq_num});
  endproperty
  a_vec_num: assert property (p_vec_num) else $error("Vector is not source plus 16");

  property p_vec_addr;
    @(posedge sys_clk) disable iff (!rst_b || !ce)
      irq_req |-> irq_vec_addr == `IPVC_PERIPH_VEC_ADDR + 32'(irq_num) * 32'd4;
  endproperty
  a_vec_addr: assert property (p_vec_addr) else $error("Vector address wrong");

  property p_assigned;
    @(posedge sys_clk) disable iff (!rst_b || !ce)
      irq_req |-> ASSIGNED_SRC[irq_num];
  endproperty
  a_assigned: assert property (p_assigned) else $error("Unassigned source offered");

  property p_stacked;
    @(posedge sys_clk) disable iff (!rst_b || !ce)
      (core_ack && irq_req) |=> stacked_vector == $past(irq_vector)
        && exc_kind == ipvc_pkg::IPVC_EXC_PERIPH;
  endproperty
  a_stacked: assert property (p_stacked) else $error("Stacked vector mismatch");

  // The offered level lags the store by one edge, so only compare while it is steady
  property p_prio_field;
    @(posedge sys_clk) disable iff (!rst_b || !ce)
      irq_req && $stable(prio_flat) |-> irq_prio == prio_flat[2*irq_num +: 2];
  endproperty
  a_prio_field: assert property (p_prio_field) else $error("Offered level not stored");

  property p_zero_bits;
    @(posedge sys_clk) disable iff (!rst_b || !ce)
      reg_rvalid |-> (reg_rdata & ~`IPVC_FIELD_MASK) == 32'h00000000;
  endproperty
  a_zero_bits: assert property (p_zero_bits) else $error("Unused bits read nonzero");

  property p_readback;
    @(posedge sys_clk) disable iff (!rst_b || !ce)
      (reg_wr && !reg_rd && reg_sel < 3'd4) ##1 (reg_rd && !reg_wr && $stable(reg_sel))
        |=> reg_rdata == ($past(reg_wdata, 2) & `IPVC_FIELD_MASK);
  endproperty
  a_readback: assert property (p_readback) else $error("Readback not masked write");

endmodule : ipvc_top
